/* rtl/bus_master_pkg.sv */
// Constants shared by the programmable burst master and its address stepper
package bus_master_pkg;

  localparam int AW     = 32;
  localparam int DW     = 32;
  localparam int CFG_AW = 8;
  localparam int NBUF   = 16;

  // Transfer type codes
  localparam logic [1:0] TR_IDLE = 2'h0;
  localparam logic [1:0] TR_BUSY = 2'h1;
  localparam logic [1:0] TR_NSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ  = 2'h3;

  // Burst type codes
  localparam logic [2:0] BU_SINGLE = 3'h0;
  localparam logic [2:0] BU_INCR   = 3'h1;
  localparam logic [2:0] BU_WRAP4  = 3'h2;
  localparam logic [2:0] BU_INCR4  = 3'h3;
  localparam logic [2:0] BU_WRAP8  = 3'h4;
  localparam logic [2:0] BU_INCR8  = 3'h5;
  localparam logic [2:0] BU_WRAP16 = 3'h6;
  localparam logic [2:0] BU_INCR16 = 3'h7;

  // Transfer sizes: byte, halfword, word, up to 1024 bits
  localparam logic [2:0] SZ_BYTE = 3'h0;
  localparam logic [2:0] SZ_HALF = 3'h1;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [2:0] SZ_MAX  = 3'h7;

  // Protection bits
  localparam int P_DATA = 0;
  localparam int P_PRIV = 1;
  localparam int P_BUF  = 2;
  localparam int P_CACH = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [1:0] DATA_WIN = 2'h1;

  // Control field positions
  localparam int C_START   = 0;
  localparam int C_WRITE   = 1;
  localparam int C_BURST   = 2;
  localparam int C_SIZE    = 5;
  localparam int C_LOCK    = 8;
  localparam int C_PROT    = 9;
  localparam int C_BUSYINS = 13;
  localparam int C_LEN     = 16;

  // Status field positions
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_ERR  = 2;
  localparam int S_CNT  = 4;

  // Reset and write-mask values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0200;
  localparam logic [31:0] CTRL_WMASK = 32'h000f_3ffe;
  localparam logic [31:0] ADDR_RST   = 32'h0000_0000;

endpackage : bus_master_pkg

/* rtl/addr_step_if.sv */
// Carrier between the master and its next-address stepper
`timescale 1ns/1ps
interface addr_step_if;
  logic [31:0] cur;
  logic [2:0]  size;
  logic [2:0]  burst;
  logic [31:0] nxt;
  modport calc (input cur, input size, input burst, output nxt);
  modport user (output cur, output size, output burst, input nxt);
endinterface : addr_step_if

/* rtl/addr_step.sv */
// Next beat address for incrementing and wrapping bursts
`timescale 1ns/1ps
module addr_step
  import bus_master_pkg::*;
(
  addr_step_if.calc st
);

  wire        is_wrap;
  wire [2:0]  wrap_sh;
  wire [31:0] step;
  wire [31:0] span;
  wire [31:0] mask;
  wire [31:0] sum;

  assign step    = 32'h0000_0001 << st.size;
  assign is_wrap = (st.burst == BU_WRAP4) | (st.burst == BU_WRAP8) | (st.burst == BU_WRAP16);
  assign wrap_sh = (st.burst == BU_WRAP4) ? 3'h2 :
                   (st.burst == BU_WRAP8) ? 3'h3 : 3'h4;
  // Wrap boundary is beats times transfer size
  assign span    = step << wrap_sh;
  assign mask    = span - 32'h0000_0001;
  assign sum     = st.cur + step;
  assign st.nxt  = is_wrap ? ((st.cur & ~mask) | (sum & mask)) : sum;

endmodule : addr_step

/* rtl/bus_master_req.sv */
// Programmable single-master bus requester with a register port
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps

module bus_master_req
  import bus_master_pkg::*;
#(
  parameter bit HAS_MMU = 1'b1
)
(
  input  wire  logic        clk,
  input  wire  logic        rst_b,
  input  wire  logic        cfg_hsel,
  input  wire  logic [31:0] cfg_haddr,
  input  wire  logic [1:0]  cfg_htrans,
  input  wire  logic        cfg_hwrite,
  input  wire  logic [2:0]  cfg_hsize,
  input  wire  logic [31:0] cfg_hwdata,
  input  wire  logic        cfg_hready,
  output logic [31:0]       cfg_hrdata,
  output logic              cfg_hreadyout,
  output logic              cfg_hresp,
  output logic [AW-1:0]     haddr,
  output logic [2:0]        hburst,
  output logic              hmastlock,
  output logic [3:0]        hprot,
  output logic [2:0]        hsize,
  output logic [1:0]        htrans,
  output logic [DW-1:0]     hwdata,
  output logic              hwrite,
  input  wire  logic        hready,
  input  wire  logic        hresp,
  input  wire  logic [DW-1:0] hrdata
);

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} state_t;

  // Register port
  logic              cfg_wr_q, cfg_rd_q;
  logic [CFG_AW-1:0] cfg_ofs_q;
  logic [31:0]       cfg_rdata_q;
  logic [31:0]       ctrl_q;
  logic [31:0]       addr_q;
  logic              go_q, done_q, err_q;
  logic [4:0]        dcnt_q;

  // Master side
  state_t            st_q, st_d;
  logic [AW-1:0]     haddr_q, haddr_d;
  logic [1:0]        htrans_q, htrans_d;
  logic [2:0]        hburst_q, hburst_d;
  logic [2:0]        hsize_q, hsize_d;
  logic [3:0]        hprot_q, hprot_d;
  logic              hlock_q, hlock_d;
  logic              hwrite_q, hwrite_d;
  logic              busyins_q, busyins_d;
  logic [4:0]        len_q, len_d;
  logic [4:0]        beat_q, beat_d;
  logic              launch;
  logic [DW-1:0]     hwdata_q;
  logic              dp_act_q;
  logic              dp_wr_q;
  logic [3:0]        dp_idx_q;
  logic [DW-1:0]     buf_q [NBUF];

  wire               cfg_take;
  wire               sel_ctrl;
  wire               sel_addr;
  wire               sel_stat;
  wire               sel_data;
  wire [3:0]         cfg_idx;
  wire               wr_ctrl, wr_addr, wr_stat, wr_data;
  wire               start_req;
  wire               running;
  wire [31:0]        stat_word;
  wire [31:0]        rd_val;
  wire               more;
  wire               beat_done;
  wire               rd_done;
  wire               done_set;
  wire [3:0]         cur_idx;
  wire [3:0]         prot_sel;

  addr_step_if stp ();

  function automatic logic [4:0] beats_of(input logic [2:0] b, input logic [3:0] n);
    logic [4:0] r;
    r = 5'h01;
    case (b)
      BU_INCR:             r = {1'b0, n} + 5'h01;
      BU_WRAP4, BU_INCR4:  r = 5'h04;
      BU_WRAP8, BU_INCR8:  r = 5'h08;
      BU_WRAP16, BU_INCR16: r = 5'h10;
      default:             r = 5'h01;
    endcase
    return r;
  endfunction : beats_of

  // Register port decode; reads take one wait state so data come from a flip-flop
  assign cfg_take  = cfg_hsel & cfg_htrans[1] & cfg_hready;
  assign sel_ctrl  = cfg_ofs_q == OFS_CTRL;
  assign sel_addr  = cfg_ofs_q == OFS_ADDR;
  assign sel_stat  = cfg_ofs_q == OFS_STAT;
  assign sel_data  = cfg_ofs_q[7:6] == DATA_WIN;
  assign cfg_idx   = cfg_ofs_q[5:2];
  assign wr_ctrl   = cfg_wr_q & sel_ctrl;
  assign wr_addr   = cfg_wr_q & sel_addr;
  assign wr_stat   = cfg_wr_q & sel_stat;
  assign wr_data   = cfg_wr_q & sel_data;
  assign running   = (st_q != ST_IDLE) | go_q;
  assign start_req = wr_ctrl & cfg_hwdata[C_START] & ~running;

  assign stat_word = ({27'h0, dcnt_q} << S_CNT)
                   | ({31'h0, err_q} << S_ERR)
                   | ({31'h0, done_q} << S_DONE)
                   | ({31'h0, running} << S_BUSY);

  assign rd_val = sel_ctrl ? ctrl_q :
                  sel_addr ? addr_q :
                  sel_stat ? stat_word :
                  sel_data ? buf_q[cfg_idx] : 32'h0000_0000;

  assign cfg_hrdata    = cfg_rdata_q;
  assign cfg_hreadyout = ~cfg_rd_q;
  assign cfg_hresp     = 1'b0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_wr_q    <= 1'b0;
      cfg_rd_q    <= 1'b0;
      cfg_ofs_q   <= '0;
      cfg_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_wr_q <= cfg_take & cfg_hwrite;
      cfg_rd_q <= cfg_take & ~cfg_hwrite;
      if (cfg_take)
        cfg_ofs_q <= cfg_haddr[CFG_AW-1:0];
      if (cfg_rd_q)
        cfg_rdata_q <= rd_val;
    end
  end

  // Start is a pulse field; it is not stored and reads back as zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= CTRL_RST;
      addr_q <= ADDR_RST;
    end
    else
    begin
      if (wr_ctrl & ~running)
        ctrl_q <= cfg_hwdata & CTRL_WMASK;
      if (wr_addr & ~running)
        addr_q <= cfg_hwdata;
    end
  end

  // Sticky flags: a hardware set wins over a clear in the same cycle
  assign done_set = hready & (st_q == ST_DRAIN);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      go_q   <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      dcnt_q <= 5'h00;
    end
    else
    begin
      go_q   <= start_req | (go_q & ~launch);
      done_q <= done_set | (done_q & ~(wr_stat & cfg_hwdata[S_DONE]));
      err_q  <= (beat_done & hresp) | (err_q & ~(wr_stat & cfg_hwdata[S_ERR]));
      if (launch)
        dcnt_q <= 5'h00;
      else if (beat_done)
        dcnt_q <= dcnt_q + 5'h01;
    end
  end

  // Next beat address from the stepper
  assign stp.cur   = haddr_q;
  assign stp.size  = hsize_q;
  assign stp.burst = hburst_q;

  addr_step u_step (
    .st (stp)
  );

  assign more     = beat_q < len_q;
  assign prot_sel = HAS_MMU ? ctrl_q[C_PROT +: 4] : {2'h0, ctrl_q[C_PROT +: 2]};

  // Address phase sequencing; nothing moves while ready is low
  always_comb
  begin
    st_d      = st_q;
    haddr_d   = haddr_q;
    htrans_d  = htrans_q;
    hburst_d  = hburst_q;
    hsize_d   = hsize_q;
    hprot_d   = hprot_q;
    hlock_d   = hlock_q;
    hwrite_d  = hwrite_q;
    busyins_d = busyins_q;
    len_d     = len_q;
    beat_d    = beat_q;
    launch    = 1'b0;
    if (hready)
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (go_q)
          begin
            launch    = 1'b1;
            st_d      = ST_RUN;
            haddr_d   = addr_q;
            htrans_d  = TR_NSEQ;
            hburst_d  = ctrl_q[C_BURST +: 3];
            hsize_d   = ctrl_q[C_SIZE +: 3];
            hprot_d   = prot_sel;
            hlock_d   = ctrl_q[C_LOCK];
            hwrite_d  = ctrl_q[C_WRITE];
            busyins_d = ctrl_q[C_BUSYINS];
            len_d     = beats_of(ctrl_q[C_BURST +: 3], ctrl_q[C_LEN +: 4]);
            beat_d    = 5'h01;
          end
        end
        ST_RUN:
        begin
          if (!more)
          begin
            st_d     = ST_DRAIN;
            htrans_d = TR_IDLE;
            hlock_d  = 1'b0;
          end
          else if (busyins_q && htrans_q != TR_BUSY)
          begin
            // Busy cycle already shows the next beat's address
            htrans_d = TR_BUSY;
            haddr_d  = stp.nxt;
          end
          else
          begin
            htrans_d = TR_SEQ;
            haddr_d  = (htrans_q == TR_BUSY) ? haddr_q : stp.nxt;
            beat_d   = beat_q + 5'h01;
          end
        end
        ST_DRAIN:
        begin
          st_d = ST_IDLE;
        end
        default:
        begin
          st_d     = ST_IDLE;
          htrans_d = TR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q      <= ST_IDLE;
      haddr_q   <= '0;
      htrans_q  <= TR_IDLE;
      hburst_q  <= BU_SINGLE;
      hsize_q   <= SZ_WORD;
      hprot_q   <= 4'h0;
      hlock_q   <= 1'b0;
      hwrite_q  <= 1'b0;
      busyins_q <= 1'b0;
      len_q     <= 5'h01;
      beat_q    <= 5'h00;
    end
    else
    begin
      st_q      <= st_d;
      haddr_q   <= haddr_d;
      htrans_q  <= htrans_d;
      hburst_q  <= hburst_d;
      hsize_q   <= hsize_d;
      hprot_q   <= hprot_d;
      hlock_q   <= hlock_d;
      hwrite_q  <= hwrite_d;
      busyins_q <= busyins_d;
      len_q     <= len_d;
      beat_q    <= beat_d;
    end
  end

  // Data phase pipeline: one beat behind the address phase
  assign beat_done = hready & dp_act_q;
  assign rd_done   = beat_done & ~dp_wr_q;
  assign cur_idx   = 4'(beat_q - 5'h01);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dp_act_q <= 1'b0;
      dp_wr_q  <= 1'b0;
      dp_idx_q <= 4'h0;
      hwdata_q <= '0;
    end
    else if (hready)
    begin
      dp_act_q <= htrans_q[1];
      dp_wr_q  <= hwrite_q;
      dp_idx_q <= cur_idx;
      if (htrans_q[1] & hwrite_q)
        hwdata_q <= buf_q[cur_idx];
    end
  end

  // Beat buffer; a read beat landing wins over a software write to the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NBUF; i++)
        buf_q[i] <= '0;
    end
    else if (rd_done)
      buf_q[dp_idx_q] <= hrdata;
    else if (wr_data)
      buf_q[cfg_idx] <= cfg_hwdata;
  end

  assign haddr     = haddr_q;
  assign htrans    = htrans_q;
  assign hburst    = hburst_q;
  assign hsize     = hsize_q;
  assign hprot     = hprot_q;
  assign hmastlock = hlock_q;
  assign hwrite    = hwrite_q;
  assign hwdata    = hwdata_q;

endmodule : bus_master_req

/* verif/bus_master_req_properties.sv */
// Concurrent checks on the burst master request port
`timescale 1ns/1ps
module bus_master_req_properties
  import bus_master_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic [AW-1:0] haddr,
  input wire logic [2:0]    hburst,
  input wire logic          hmastlock,
  input wire logic [3:0]    hprot,
  input wire logic [2:0]    hsize,
  input wire logic [1:0]    htrans,
  input wire logic [DW-1:0] hwdata,
  input wire logic          hwrite,
  input wire logic          hready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic [11:0] ctl = {hburst, hsize, hprot, hwrite, hmastlock};

  AST_HOLD_REQ: assert property (!hready |=> $stable({haddr, htrans, ctl}))
    else $error("request moved in wait state");
  AST_HOLD_WDATA: assert property (!hready |=> $stable(hwdata))
    else $error("write data moved in wait state");
  AST_LOCK_IDLE: assert property (htrans == TR_IDLE |-> !hmastlock)
    else $error("lock high with idle");
  // BUSY and SEQ both have bit 0 set, so this covers every beat after the first
  AST_BURST_CONST: assert property (htrans[0] |-> $stable(ctl))
    else $error("control changed inside burst");
  AST_NO_SEQ_AFTER_IDLE: assert property (htrans[0] |-> $past(htrans) != TR_IDLE)
    else $error("burst beat after idle");
  AST_INCR_STEP: assert property (hready && htrans == TR_NSEQ && hburst[0] |=>
    htrans == TR_IDLE || haddr == $past(haddr) + (32'h1 << hsize))
    else $error("incrementing step wrong");
  AST_WRAP4_BOUND: assert property (hready && htrans == TR_NSEQ && hburst == BU_WRAP4 |=>
    (haddr >> ({1'b0, hsize} + 4'h2)) == ($past(haddr) >> ({1'b0, hsize} + 4'h2)))
    else $error("wrap left its boundary");
  AST_RESET_IDLE: assert property ($rose(rst_b) |-> htrans == TR_IDLE && !hmastlock)
    else $error("request active after reset");
endmodule : bus_master_req_properties

/* verif/bus_slave_model.sv */
// Slave answering the burst master with random waits and optional errors
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] haddr,
  input  wire logic [31:0] hwdata,
  input  wire logic        wait_en,
  input  wire logic        err_en,
  output logic             hready,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  logic [31:0] wa [16];
  logic [31:0] wd [16];
  logic [4:0]  n_q;
  logic [4:0]  di_q;
  logic        dw_q;
  int          seed = 32'h31fc;
  wire  [4:0]  idx = (htrans == 2'h2) ? 5'h0 : n_q;

  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      hready <= 1'b1;
      hresp  <= 1'b0;
      hrdata <= 32'h0;
      n_q    <= 5'h0;
      di_q   <= 5'h0;
      dw_q   <= 1'b0;
    end
    else if (!hready)
      hready <= 1'b1;
    else
    begin
      if (dw_q)
        wd[di_q[3:0]] <= hwdata;
      dw_q   <= htrans[1] && hwrite;
      hresp  <= err_en && htrans[1];
      hready <= !(htrans[1] && (err_en || (wait_en && $random(seed) & 1)));
      // Outside a read data phase the bus carries no data, so it keeps changing
      hrdata <= (htrans[1] && !hwrite) ? haddr ^ 32'h0bad_0000 : ~hrdata;
      if (htrans[1])
      begin
        wa[idx[3:0]] <= haddr;
        di_q <= idx;
        n_q  <= idx + 5'h1;
      end
    end
endmodule : bus_slave_model

/* verif/bus_master_req_tb_top.sv */
// Self-checking bench for the programmable burst master
`timescale 1ns/1ps
module bus_master_req_tb_top
  import bus_master_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] c_addr = 32'h0;
  logic [31:0] c_wdata = 32'h0;
  logic [1:0]  c_trans = 2'h0;
  logic        c_write = 1'b0;
  logic        err_en = 1'b0;
  logic        wait_en = 1'b0;
  logic [31:0] cfg_hrdata, haddr, hwdata, hrdata, rd_q;
  logic        cfg_hreadyout, cfg_hresp, hmastlock, hwrite, hready, hresp;
  logic [2:0]  hburst, hsize;
  logic [3:0]  hprot;
  logic [1:0]  htrans;
  logic [11:0] ctl_seen;
  int          fail_count = 0;
  int          check_count = 0;
  int          seed = 32'h31fc;

  always #50 clk = ~clk;

  bus_master_req dut_u (.clk(clk), .rst_b(rst_b), .cfg_hsel(1'b1), .cfg_haddr(c_addr),
    .cfg_htrans(c_trans), .cfg_hwrite(c_write), .cfg_hsize(SZ_WORD), .cfg_hwdata(c_wdata),
    .cfg_hready(cfg_hreadyout), .cfg_hrdata(cfg_hrdata), .cfg_hreadyout(cfg_hreadyout),
    .cfg_hresp(cfg_hresp), .haddr(haddr), .hburst(hburst), .hmastlock(hmastlock), .hprot(hprot),
    .hsize(hsize), .htrans(htrans), .hwdata(hwdata), .hwrite(hwrite), .hready(hready),
    .hresp(hresp), .hrdata(hrdata));

  bus_slave_model slv_u (.clk(clk), .rst_b(rst_b), .htrans(htrans), .hwrite(hwrite),
    .haddr(haddr), .hwdata(hwdata), .wait_en(wait_en), .err_en(err_en), .hready(hready),
    .hresp(hresp), .hrdata(hrdata));

  always @(posedge clk)
    if (hready && htrans == TR_NSEQ)
      ctl_seen <= {hburst, hsize, hprot, hwrite, hmastlock};

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Ready and read data are taken at the rising edge, before the design's flops move; n counts wait states
  task automatic wait_rdy(output int n);
    n = 0;
    @(posedge clk);
    while (cfg_hreadyout !== 1'b1)
    begin
      n++;
      @(posedge clk);
    end
    rd_q = cfg_hrdata;
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    c_addr  <= {24'h0, a};
    c_write <= w;
    c_trans <= TR_NSEQ;
    wait_rdy(n);
    c_trans <= TR_IDLE;
    c_wdata <= d;
    wait_rdy(n);
    // Reads carry exactly one wait state, writes none
    check(32'(n), {31'h0, ~w});
    check({31'h0, cfg_hresp}, 32'h0);
  endtask : xfer

  function automatic logic [31:0] beat_addr(input logic [31:0] a, input int sz, input int nb,
                                            input int i, input bit wrap);
    logic [31:0] m;
    m = nb * sz - 1;
    return wrap ? (a & ~m) | ((a + i * sz) & m) : a + i * sz;
  endfunction : beat_addr

  task automatic run_burst(input logic [2:0] b, input logic e);
    logic [31:0] a, cw, ea;
    logic [31:0] dat [16];
    int          sz, nb;
    cw = $random(seed) & CTRL_WMASK;
    cw[4:2] = b;
    cw[6] = cw[6] & ~cw[5];
    cw[7] = 1'b0;
    sz = 1 << cw[7:5];
    nb = (b == BU_SINGLE) ? 1 : (b == BU_INCR) ? cw[19:16] + 1 : 4 << ((b - 2) / 2);
    a = $random(seed) & ~(sz - 1);
    err_en <= e;
    wait_en <= 1'b1;
    for (int i = 0; i < nb; i++)
    begin
      dat[i] = $random(seed);
      xfer(1'b1, 8'h40 + 8'(4 * i), dat[i]);
    end
    xfer(1'b1, OFS_ADDR, a);
    xfer(1'b1, OFS_CTRL, cw | 32'h1);
    // Long bursts are still running here, so this write must be dropped
    if (nb >= 4)
      xfer(1'b1, OFS_ADDR, ~a);
    repeat (300)
    begin
      xfer(1'b0, OFS_STAT, 32'h0);
      if (rd_q[S_DONE] === 1'b1)
        break;
    end
    check({29'h0, rd_q[2:0]}, {29'h0, e, 2'b10});
    check({27'h0, rd_q[8:4]}, 32'(nb));
    check({20'h0, ctl_seen}, {20'h0, b, cw[7:5], cw[12:9], cw[1], cw[8]});
    xfer(1'b0, OFS_ADDR, 32'h0);
    check(rd_q, a);
    for (int i = 0; i < nb; i++)
    begin
      ea = beat_addr(a, sz, nb, i, b > 1 && !b[0]);
      check(slv_u.wa[i], ea);
      if (cw[1])
        check(slv_u.wd[i], dat[i]);
      else
      begin
        xfer(1'b0, 8'h40 + 8'(4 * i), 32'h0);
        check(rd_q, ea ^ 32'h0bad_0000);
      end
    end
    xfer(1'b1, OFS_STAT, 32'h6);
  endtask : run_burst

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  initial
  begin
    #5_000_000;
    fail_count++;
    results;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    xfer(1'b0, OFS_CTRL, 32'h0);
    check(rd_q, CTRL_RST);
    xfer(1'b0, OFS_STAT, 32'h0);
    check(rd_q, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0);
    check(rd_q, 32'h0);
    for (int b = 0; b < 8; b++)
      run_burst(3'(b), 1'b0);
    repeat (6) run_burst(3'($random(seed)), 1'b0);
    // Reset in the middle of a long read burst must leave the block idle
    xfer(1'b1, OFS_CTRL, 32'h0000_005d);
    repeat (4) @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    check({30'h0, htrans}, {30'h0, TR_IDLE});
    check(haddr, 32'h0);
    xfer(1'b0, OFS_STAT, 32'h0);
    check(rd_q, 32'h0);
    xfer(1'b0, OFS_CTRL, 32'h0);
    check(rd_q, CTRL_RST);
    run_burst(BU_INCR4, 1'b1);
    results;
  end
endmodule : bus_master_req_tb_top

bind bus_master_req bus_master_req_properties chk_u (.clk(clk), .rst_b(rst_b), .haddr(haddr),
  .hburst(hburst), .hmastlock(hmastlock), .hprot(hprot), .hsize(hsize), .htrans(htrans),
  .hwdata(hwdata), .hwrite(hwrite), .hready(hready));
